/* verilog/temp_regs.sv */
`timescale 1ns/1ns
module temp_regs (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        INDEX_WR,
  input  wire logic [7:0]  INDEX_IN,
  input  wire logic        DATA_WR,
  input  wire logic [7:0]  DATA_IN,
  input  wire logic        DATA_RD,
  output logic      [7:0]  RD_DATA,
  output logic             RD_VALID,
  input  wire logic        ADDR_RD,
  input  wire logic        CONV_BUSY,
  input  wire logic        CONV_DONE,
  input  wire logic [11:0] LOCAL_RESULT,
  input  wire logic [11:0] REMOTE_RESULT,
  input  wire logic        REMOTE_OPEN,
  input  wire logic [11:0] LOCAL_HIGH_LIMIT,
  input  wire logic [11:0] LOCAL_LOW_LIMIT,
  input  wire logic [11:0] REMOTE_HIGH_LIMIT,
  input  wire logic [11:0] REMOTE_LOW_LIMIT,
  input  wire logic [11:0] LOCAL_CRIT_LIMIT,
  input  wire logic [11:0] REMOTE_CRIT_LIMIT,
  input  wire logic [7:0]  CRIT_HYSTERESIS,
  output logic             CONV_ENABLE,
  output logic             EXT_RANGE,
  output logic             CRIT_N,
  output logic             PIN6_N
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  index_q;
  logic [7:0]  index_d;
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic [4:0]  sticky_q;
  logic [4:0]  sticky_d;
  logic [4:0]  cause_q;
  logic [4:0]  cause_d;
  logic [1:0]  crit_q;
  logic [1:0]  crit_d;
  logic [1:0]  hot_q;
  logic [1:0]  hot_d;
  logic        latch_q;
  logic        latch_d;
  logic [7:0]  rd_data_q;
  logic [7:0]  rd_data_d;
  logic        rd_valid_q;

  // ----------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------
  logic [11:0] results  [temp_regs_pkg::NUM_CHANNELS];
  logic [7:0]  idx_hi   [temp_regs_pkg::NUM_CHANNELS];
  logic [7:0]  idx_lo   [temp_regs_pkg::NUM_CHANNELS];
  logic [7:0]  hi_bytes [temp_regs_pkg::NUM_CHANNELS];
  logic [7:0]  lo_bytes [temp_regs_pkg::NUM_CHANNELS];
  logic [1:0]  pair_hit;

  assign results[temp_regs_pkg::CH_LOCAL]  = LOCAL_RESULT;
  assign results[temp_regs_pkg::CH_REMOTE] = REMOTE_RESULT;
  assign idx_hi[temp_regs_pkg::CH_LOCAL]   = temp_regs_pkg::IDX_LOCAL_HI;
  assign idx_lo[temp_regs_pkg::CH_LOCAL]   = temp_regs_pkg::IDX_LOCAL_LO;
  assign idx_hi[temp_regs_pkg::CH_REMOTE]  = temp_regs_pkg::IDX_REMOTE_HI;
  assign idx_lo[temp_regs_pkg::CH_REMOTE]  = temp_regs_pkg::IDX_REMOTE_LO;

  result_if rif [temp_regs_pkg::NUM_CHANNELS] ();

  genvar ch;
  generate
    for (ch = 0; ch < temp_regs_pkg::NUM_CHANNELS; ch++) begin : g_chan
      assign pair_hit[ch]         = (index_q == idx_hi[ch]) | (index_q == idx_lo[ch]);
      assign rif[ch].conv_done    = CONV_DONE;
      assign rif[ch].new_result   = results[ch];
      assign rif[ch].rd_hi        = DATA_RD & (index_q == idx_hi[ch]);
      assign rif[ch].rd_lo        = DATA_RD & (index_q == idx_lo[ch]);
      assign rif[ch].rd_other     = DATA_RD & ~pair_hit[ch];
      assign hi_bytes[ch]         = rif[ch].hi_byte;
      assign lo_bytes[ch]         = rif[ch].lo_byte;
      result_pair u_pair (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .rif     (rif[ch].owner)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // index and configuration
  // ----------------------------------------------------------------
  logic cfg_wr;
  logic mask_bit;
  logic comparator_mode;

  assign index_d         = INDEX_WR ? INDEX_IN : index_q;
  assign cfg_wr          = DATA_WR & (index_q == temp_regs_pkg::IDX_CFG_WR);
  // only writable bits are stored; other targets are ignored
  assign cfg_d           = cfg_wr ? (DATA_IN & temp_regs_pkg::CFG_WR_MASK) : cfg_q;
  assign mask_bit        = cfg_q[temp_regs_pkg::CFG_MASK_BIT];
  assign comparator_mode = cfg_q[temp_regs_pkg::CFG_PIN_BIT];
  assign CONV_ENABLE     = ~cfg_q[temp_regs_pkg::CFG_STOP_BIT];
  assign EXT_RANGE       = cfg_q[temp_regs_pkg::CFG_RANGE_BIT];

  // ----------------------------------------------------------------
  // limit comparisons
  // ----------------------------------------------------------------
  logic [11:0] hys12;
  logic [12:0] loc_rel;
  logic [12:0] rem_rel;
  logic [12:0] loc_hrel;
  logic [12:0] rem_hrel;
  logic        loc_crit_cond;
  logic        rem_crit_cond;
  logic        loc_crit_rel;
  logic        rem_crit_rel;
  logic        loc_high_rel;
  logic        rem_high_rel;

  assign hys12    = {CRIT_HYSTERESIS, 4'h0};
  assign loc_rel  = {1'b0, LOCAL_CRIT_LIMIT} - {1'b0, hys12};
  assign rem_rel  = {1'b0, REMOTE_CRIT_LIMIT} - {1'b0, hys12};
  assign loc_hrel = {1'b0, LOCAL_HIGH_LIMIT} - {1'b0, hys12};
  assign rem_hrel = {1'b0, REMOTE_HIGH_LIMIT} - {1'b0, hys12};
  assign loc_crit_cond = LOCAL_RESULT > LOCAL_CRIT_LIMIT;
  assign rem_crit_cond = REMOTE_RESULT > REMOTE_CRIT_LIMIT;
  // release at or below limit minus hysteresis; a limit below the margin releases never
  assign loc_crit_rel  = ~loc_rel[12] & ({1'b0, LOCAL_RESULT} <= loc_rel);
  assign rem_crit_rel  = ~rem_rel[12] & ({1'b0, REMOTE_RESULT} <= rem_rel);
  assign loc_high_rel  = ~loc_hrel[12] & ({1'b0, LOCAL_RESULT} <= loc_hrel);
  assign rem_high_rel  = ~rem_hrel[12] & ({1'b0, REMOTE_RESULT} <= rem_hrel);

  // causes ordered as status bits 6..2
  logic [4:0] cause_now;
  assign cause_now = {LOCAL_RESULT > LOCAL_HIGH_LIMIT,
                      LOCAL_RESULT < LOCAL_LOW_LIMIT,
                      REMOTE_RESULT > REMOTE_HIGH_LIMIT,
                      REMOTE_RESULT < REMOTE_LOW_LIMIT,
                      REMOTE_OPEN};
  assign cause_d = CONV_DONE ? cause_now : cause_q;

  assign crit_d[0] = CONV_DONE ? (loc_crit_cond | (crit_q[0] & ~loc_crit_rel)) :
                     crit_q[0];
  assign crit_d[1] = CONV_DONE ? (rem_crit_cond | (crit_q[1] & ~rem_crit_rel)) :
                     crit_q[1];
  // comparator-mode high states with critical-style release
  assign hot_d[0] = CONV_DONE ? (cause_now[4] | (hot_q[0] & ~loc_high_rel)) : hot_q[0];
  assign hot_d[1] = CONV_DONE ? (cause_now[2] | (hot_q[1] & ~rem_high_rel)) : hot_q[1];

  // ----------------------------------------------------------------
  // status flags and interrupt latch
  // ----------------------------------------------------------------
  logic       status_rd;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [4:0] sticky_sel;
  logic [4:0] status_flags;

  assign status_rd  = DATA_RD & (index_q == temp_regs_pkg::IDX_STATUS);
  // in comparator mode only the open flag stays sticky
  assign sticky_sel = comparator_mode ? 5'h01 : 5'h1f;
  assign flag_set   = (CONV_DONE ? cause_now : 5'h00) & sticky_sel;
  // set wins over clear; clear only once the cause is gone
  assign flag_clr   = status_rd ? ~cause_q : 5'h00;
  assign sticky_d   = (flag_set | (sticky_q & ~flag_clr)) & sticky_sel;
  assign status_flags = comparator_mode ?
                        {hot_q[0], cause_q[3], hot_q[1], cause_q[1], sticky_q[0]} :
                        sticky_q;

  logic any_flag;
  logic release_ok;
  assign any_flag   = |sticky_q;
  assign release_ok = ADDR_RD & ~any_flag & ~(|cause_q);
  assign latch_d    = comparator_mode ? 1'b0 :
                      (any_flag | (latch_q & ~release_ok));

  assign CRIT_N = ~(crit_q[0] | crit_q[1]);
  assign PIN6_N = comparator_mode ? ~(hot_q[0] | hot_q[1]) :
                  ~(latch_q & ~mask_bit);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  assign status_byte = {CONV_BUSY, status_flags, crit_q[1], crit_q[0]};

  always_comb begin
    case (index_q)
      temp_regs_pkg::IDX_LOCAL_HI:  rd_data_d = hi_bytes[temp_regs_pkg::CH_LOCAL];
      temp_regs_pkg::IDX_LOCAL_LO:  rd_data_d = lo_bytes[temp_regs_pkg::CH_LOCAL];
      temp_regs_pkg::IDX_REMOTE_HI: rd_data_d = hi_bytes[temp_regs_pkg::CH_REMOTE];
      temp_regs_pkg::IDX_REMOTE_LO: rd_data_d = lo_bytes[temp_regs_pkg::CH_REMOTE];
      temp_regs_pkg::IDX_STATUS:    rd_data_d = status_byte;
      temp_regs_pkg::IDX_CFG_RD:    rd_data_d = cfg_q;
      default:                      rd_data_d = 8'h00;
    endcase
  end

  assign RD_DATA  = rd_data_q;
  assign RD_VALID = rd_valid_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      index_q    <= temp_regs_pkg::INDEX_RESET;
      cfg_q      <= temp_regs_pkg::CFG_RESET;
      sticky_q   <= 5'h00;
      cause_q    <= 5'h00;
      crit_q     <= 2'h0;
      hot_q      <= 2'h0;
      latch_q    <= 1'b0;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      index_q    <= index_d;
      cfg_q      <= cfg_d;
      sticky_q   <= sticky_d;
      cause_q    <= cause_d;
      crit_q     <= crit_d;
      hot_q      <= hot_d;
      latch_q    <= latch_d;
      rd_data_q  <= DATA_RD ? rd_data_d : rd_data_q;
      rd_valid_q <= DATA_RD;
    end
  end
endmodule : temp_regs

/* verilog/temp_regs_pkg.sv */
package temp_regs_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LOCAL_HI  = 8'h00;
  localparam logic [7:0] IDX_REMOTE_HI = 8'h01;
  localparam logic [7:0] IDX_STATUS    = 8'h02;
  localparam logic [7:0] IDX_CFG_RD    = 8'h03;
  localparam logic [7:0] IDX_CFG_WR    = 8'h09;
  localparam logic [7:0] IDX_REMOTE_LO = 8'h10;
  localparam logic [7:0] IDX_LOCAL_LO  = 8'h15;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] INDEX_RESET   = 8'h00;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [7:0] CFG_WR_MASK   = 8'he4;
  localparam int         CFG_MASK_BIT  = 7;
  localparam int         CFG_STOP_BIT  = 6;
  localparam int         CFG_PIN_BIT   = 5;
  localparam int         CFG_RANGE_BIT = 2;
  localparam int         ST_BUSY       = 7;
  localparam int         ST_LOC_HIGH   = 6;
  localparam int         ST_LOC_LOW    = 5;
  localparam int         ST_REM_HIGH   = 4;
  localparam int         ST_REM_LOW    = 3;
  localparam int         ST_OPEN       = 2;
  localparam int         ST_REM_CRIT   = 1;
  localparam int         ST_LOC_CRIT   = 0;
  localparam int         NUM_CHANNELS  = 2;
  localparam int         CH_LOCAL      = 0;
  localparam int         CH_REMOTE     = 1;
endpackage : temp_regs_pkg

/* verilog/result_if.sv */
`timescale 1ns/1ns
interface result_if;
  logic        conv_done;
  logic [11:0] new_result;
  logic        rd_hi;
  logic        rd_lo;
  logic        rd_other;
  logic [7:0]  hi_byte;
  logic [7:0]  lo_byte;
  modport owner (input conv_done, new_result, rd_hi, rd_lo, rd_other,
                 output hi_byte, lo_byte);
  modport user  (output conv_done, new_result, rd_hi, rd_lo, rd_other,
                 input hi_byte, lo_byte);
endinterface : result_if

/* verilog/result_pair.sv */
`timescale 1ns/1ns
module result_pair (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  result_if.owner  rif
);
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic       hi_lock_q;
  logic       hi_lock_d;
  logic       lo_lock_q;
  logic       lo_lock_d;

  // ----------------------------------------------------------------
  // byte-pair freeze
  // ----------------------------------------------------------------
  // a repeated read of the same byte keeps the partner frozen
  assign hi_lock_d = rif.rd_other ? 1'b0 :
                     rif.rd_lo    ? ~lo_lock_q :
                     rif.rd_hi    ? 1'b0 : hi_lock_q;
  assign lo_lock_d = rif.rd_other ? 1'b0 :
                     rif.rd_hi    ? ~hi_lock_q :
                     rif.rd_lo    ? 1'b0 : lo_lock_q;
  assign hi_d = (rif.conv_done & ~hi_lock_q) ? rif.new_result[11:4] : hi_q;
  assign lo_d = (rif.conv_done & ~lo_lock_q) ? {rif.new_result[3:0], 4'h0} : lo_q;
  assign rif.hi_byte = hi_q;
  assign rif.lo_byte = lo_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      hi_q      <= temp_regs_pkg::RESULT_RESET;
      lo_q      <= temp_regs_pkg::RESULT_RESET;
      hi_lock_q <= 1'b0;
      lo_lock_q <= 1'b0;
    end else begin
      hi_q      <= hi_d;
      lo_q      <= lo_d;
      hi_lock_q <= hi_lock_d;
      lo_lock_q <= lo_lock_d;
    end
  end
endmodule : result_pair

/* testbench/temp_regs_properties.sv */
`timescale 1ns/1ns
// ------------
// port checker
// ------------
module temp_regs_checker (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        INDEX_WR,
  input wire logic [7:0]  INDEX_IN,
  input wire logic        DATA_WR,
  input wire logic [7:0]  DATA_IN,
  input wire logic        DATA_RD,
  input wire logic [7:0]  RD_DATA,
  input wire logic        RD_VALID,
  input wire logic        ADDR_RD,
  input wire logic        CONV_BUSY,
  input wire logic        CONV_DONE,
  input wire logic [11:0] LOCAL_RESULT,
  input wire logic [11:0] LOCAL_CRIT_LIMIT,
  input wire logic        CONV_ENABLE,
  input wire logic        EXT_RANGE,
  input wire logic        CRIT_N,
  input wire logic        PIN6_N
);
  logic [7:0] idx_q;
  logic [7:0] cfg_q;
  wire        cfg_hit   = DATA_WR && (idx_q == temp_regs_pkg::IDX_CFG_WR);
  wire        st_rd     = DATA_RD && (idx_q == temp_regs_pkg::IDX_STATUS);
  wire  [7:0] idx_d     = INDEX_WR ? INDEX_IN : idx_q;
  wire  [7:0] cfg_d     = cfg_hit ? (DATA_IN & temp_regs_pkg::CFG_WR_MASK) : cfg_q;
  wire        cfg_range = cfg_q[temp_regs_pkg::CFG_RANGE_BIT];
  wire        cfg_run   = !cfg_q[temp_regs_pkg::CFG_STOP_BIT];
  wire        cfg_irq   = !cfg_q[temp_regs_pkg::CFG_PIN_BIT];
  always_ff @(posedge SYS_CLK) begin
    idx_q <= RESET_N ? idx_d : 8'h00;
    cfg_q <= RESET_N ? cfg_d : 8'h00;
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  AST_RD_VALID: assert property (DATA_RD |=> RD_VALID) else $error("read gave no valid");
  AST_RD_HOLD: assert property (!DATA_RD |=> !RD_VALID && $stable(RD_DATA))
    else $error("read port moved without a read");
  AST_RESET_OUT: assert property (
    $rose(RESET_N) |-> CONV_ENABLE && !EXT_RANGE && CRIT_N && PIN6_N)
    else $error("outputs not at reset values");
  AST_CFG_WR: assert property (
    cfg_hit |=> EXT_RANGE == cfg_range && CONV_ENABLE == cfg_run)
    else $error("config write not applied");
  AST_CFG_KEEP: assert property (
    DATA_WR && !cfg_hit |=> $stable({EXT_RANGE, CONV_ENABLE}))
    else $error("config moved on other write");
  AST_UNMAPPED: assert property (DATA_RD && idx_q > 8'h15 |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  AST_BUSY: assert property (st_rd |=> RD_DATA[7] == $past(CONV_BUSY))
    else $error("busy bit wrong");
  AST_CRIT_SET: assert property (
    CONV_DONE && LOCAL_RESULT > LOCAL_CRIT_LIMIT |=> !CRIT_N)
    else $error("critical output not asserted");
  AST_CRIT_QUIET: assert property (!CONV_DONE |=> $stable(CRIT_N))
    else $error("critical output moved without conversion");
  AST_LATCH_HOLD: assert property (
    !PIN6_N && cfg_irq && !ADDR_RD && !DATA_WR |=> !PIN6_N)
    else $error("interrupt latch released without address read");
endmodule : temp_regs_checker

bind temp_regs temp_regs_checker i_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .INDEX_WR(INDEX_WR), .INDEX_IN(INDEX_IN),
  .DATA_WR(DATA_WR), .DATA_IN(DATA_IN), .DATA_RD(DATA_RD), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .ADDR_RD(ADDR_RD), .CONV_BUSY(CONV_BUSY), .CONV_DONE(CONV_DONE),
  .LOCAL_RESULT(LOCAL_RESULT), .LOCAL_CRIT_LIMIT(LOCAL_CRIT_LIMIT),
  .CONV_ENABLE(CONV_ENABLE), .EXT_RANGE(EXT_RANGE), .CRIT_N(CRIT_N), .PIN6_N(PIN6_N)
);

/* testbench/host_model.sv */
`timescale 1ns/1ns
// ----------------------
// register host
// ----------------------
module host_model (
  input  wire logic       SYS_CLK,
  output logic            INDEX_WR = 1'b0,
  output logic      [7:0] INDEX_IN = 8'h00,
  output logic            DATA_WR  = 1'b0,
  output logic      [7:0] DATA_IN  = 8'h00,
  output logic            DATA_RD  = 1'b0,
  output logic            ADDR_RD  = 1'b0,
  input  wire logic [7:0] RD_DATA,
  input  wire logic       RD_VALID
);
  // index write first, then the data access at that index
  task automatic access(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rd);
    INDEX_WR = 1'b1;
    INDEX_IN = idx;
    @(posedge SYS_CLK);
    #1;
    INDEX_WR = 1'b0;
    INDEX_IN = ~idx;
    DATA_WR  = wr;
    DATA_RD  = !wr;
    DATA_IN  = wd;
    @(posedge SYS_CLK);
    #1;
    DATA_WR  = 1'b0;
    DATA_RD  = 1'b0;
    DATA_IN  = ~wd;
    rd       = RD_VALID ? RD_DATA : 8'hxx;
  endtask : access
  task automatic addr_read();
    ADDR_RD = 1'b1;
    @(posedge SYS_CLK);
    #1;
    ADDR_RD = 1'b0;
  endtask : addr_read
endmodule : host_model

/* testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        conv_busy = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] loc_res   = 12'h000;
  logic [11:0] rem_res   = 12'h000;
  logic        rem_open  = 1'b0;
  logic [11:0] high_lim  = 12'h300;
  logic [11:0] low_lim   = 12'h100;
  logic [11:0] crit_lim  = 12'h400;
  logic [7:0]  hyst      = 8'h05;
  logic [7:0]  zidx [6]  = '{8'h00, 8'h01, 8'h10, 8'h15, 8'h03, 8'h50};
  logic        index_wr, data_wr, data_rd, addr_rd, rd_valid;
  logic [7:0]  index_in, data_in, rd_data, got;
  logic        conv_enable, ext_range, crit_n, pin6_n;
  int          errors     = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  always #25 sys_clk = ~sys_clk;
  host_model i_host (.SYS_CLK(sys_clk), .INDEX_WR(index_wr), .INDEX_IN(index_in),
    .DATA_WR(data_wr), .DATA_IN(data_in), .DATA_RD(data_rd), .ADDR_RD(addr_rd),
    .RD_DATA(rd_data), .RD_VALID(rd_valid));
  temp_regs i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .INDEX_WR(index_wr),
    .INDEX_IN(index_in), .DATA_WR(data_wr), .DATA_IN(data_in), .DATA_RD(data_rd),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .ADDR_RD(addr_rd), .CONV_BUSY(conv_busy),
    .CONV_DONE(conv_done), .LOCAL_RESULT(loc_res), .REMOTE_RESULT(rem_res),
    .REMOTE_OPEN(rem_open), .LOCAL_HIGH_LIMIT(high_lim), .LOCAL_LOW_LIMIT(low_lim),
    .REMOTE_HIGH_LIMIT(high_lim), .REMOTE_LOW_LIMIT(low_lim), .LOCAL_CRIT_LIMIT(crit_lim),
    .REMOTE_CRIT_LIMIT(crit_lim), .CRIT_HYSTERESIS(hyst), .CONV_ENABLE(conv_enable),
    .EXT_RANGE(ext_range), .CRIT_N(crit_n), .PIN6_N(pin6_n));
  // ----------------
  // shared tasks
  // ----------------
  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    i_host.access(idx, 1'b0, 8'h00, got);
    check(got, exp);
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_host.access(idx, 1'b1, d, got);
  endtask : wr
  task automatic pins(input logic [7:0] exp);
    check({6'h00, crit_n, pin6_n}, exp);
  endtask : pins
  task automatic conv(input logic [11:0] loc, input logic [11:0] rem);
    loc_res   = loc;
    rem_res   = rem;
    conv_done = 1'b1;
    @(posedge sys_clk);
    #1;
    conv_done = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : conv
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end
  // ----------------
  // scenarios
  // ----------------
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    pins(8'h03);
    check({6'h00, conv_enable, ext_range}, 8'h02);
    foreach (zidx[i]) rd(zidx[i], 8'h00);
    wr(8'h09, 8'he4);
    rd(8'h03, 8'he4);
    check({6'h00, conv_enable, ext_range}, 8'h01);
    wr(8'h09, 8'h00);
    conv(12'h1a3, 12'h2b5);
    rd(8'h00, 8'h1a);
    rd(8'h15, 8'h30);
    rd(8'h01, 8'h2b);
    rd(8'h10, 8'h50);
    wr(8'h00, 8'h5a);
    wr(8'h02, 8'hff);
    rd(8'h00, 8'h1a);
    rd(8'h00, 8'h1a);
    conv(12'h1c7, 12'h2b5);
    rd(8'h15, 8'h30);
    rd(8'h00, 8'h1c);
    rd(8'h10, 8'h50);
    conv(12'h1c7, 12'h2e9);
    rd(8'h01, 8'h2b);
    conv_busy = 1'b1;
    rd(8'h02, 8'h80);
    conv_busy = 1'b0;
    rd(8'h02, 8'h00);
    conv(12'h350, 12'h200);
    pins(8'h02);
    rd(8'h02, 8'h40);
    rd(8'h02, 8'h40);
    i_host.addr_read();
    pins(8'h02);
    conv(12'h200, 12'h200);
    rd(8'h02, 8'h40);
    pins(8'h02);
    rd(8'h02, 8'h00);
    i_host.addr_read();
    pins(8'h03);
    wr(8'h09, 8'h80);
    conv(12'h350, 12'h200);
    pins(8'h03);
    conv(12'h200, 12'h200);
    rd(8'h02, 8'h40);
    rd(8'h02, 8'h00);
    i_host.addr_read();
    wr(8'h09, 8'h00);
    pins(8'h03);
    conv(12'h450, 12'h200);
    pins(8'h00);
    rd(8'h02, 8'h41);
    conv(12'h3c0, 12'h200);
    pins(8'h00);
    conv(12'h3b0, 12'h200);
    pins(8'h02);
    rd(8'h02, 8'h40);
    conv(12'h200, 12'h200);
    rd(8'h02, 8'h40);
    rd(8'h02, 8'h00);
    i_host.addr_read();
    pins(8'h03);
    wr(8'h09, 8'ha0);
    conv(12'h350, 12'h200);
    pins(8'h02);
    conv(12'h2c0, 12'h200);
    rd(8'h02, 8'h40);
    conv(12'h2b0, 12'h200);
    pins(8'h03);
    rd(8'h02, 8'h00);
    conv(12'h080, 12'h200);
    rd(8'h02, 8'h20);
    pins(8'h03);
    conv(12'h200, 12'h200);
    rd(8'h02, 8'h00);
    rem_open = 1'b1;
    conv(12'h200, 12'h450);
    pins(8'h00);
    rd(8'h02, 8'h16);
    rem_open = 1'b0;
    conv(12'h200, 12'h080);
    rd(8'h02, 8'h0c);
    rd(8'h02, 8'h08);
    pins(8'h03);
    final_report();
  end
endmodule : tb_top
